// [rtl/scs_top.sv]
//
// Operation
// [R01] line sync out follows selected source raw
// [R02] frame sync out: vsync, or broad-pulse span
// [R03] open-drain interrupt on mode change, command done
// [R04] video valid high only outside blanking
// [R05] field output toggles for interlace, polarity configurable
// [R06] sync type code in bits 1:0
// [R07] hsync polarity in bit 2, 1 low
// [R08] vsync polarity in bit 3, 1 low
// [R09] bit 4 set for tri-level green sync
// [R10] bit 5 interlace, composite inputs only
// [R11] bit 6 copy protection pulses detected
// [R12] bit 7 pixel clock loop locked
// [R13] traits register live, writes ignored
//
`timescale 1ns/1ps
`default_nettype none
module scs_top
	import scs_pkg::*;
#(
	parameter int LINE_TIMEOUT  = scs_pkg::LINE_TIMEOUT_CYC,
	parameter int FRAME_TIMEOUT = scs_pkg::FRAME_TIMEOUT_CYC
) (
	input  wire logic       CLK_SYS,
	input  wire logic       RST,
	input  wire logic       HSYNC_IN,
	input  wire logic       VSYNC_IN,
	input  wire logic       GREEN_SYNC_IN,
	input  wire logic       GREEN_TRI_IN,
	input  wire logic       PLL_LOCK_IN,
	input  wire logic       PHASE_ADJUST_DONE_EVENT,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output var  logic [7:0] RDATA,
	output var  logic       RAW_LINE_SYNC_OUT,
	output var  logic       RAW_FRAME_SYNC_OUT,
	output var  logic       VIDEO_VALID_OUT,
	output var  logic       FIELD_OUT,
	output var  logic       INT_OUT,
	output var  logic       INT_OE_N
);
	import scs_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	logic [2:0] ch_s;
	logic       tri_s;
	logic       lock_s;

	scs_sync2 #(.W(5)) u_sync (
		.clk (CLK_SYS),
		.rst (RST),
		.d   ({PLL_LOCK_IN, GREEN_TRI_IN, GREEN_SYNC_IN, VSYNC_IN, HSYNC_IN}),
		.q   (pins_s)
	);
	assign ch_s   = pins_s[2:0];
	assign tri_s  = pins_s[3];
	assign lock_s = pins_s[4];

	// ----------------------------------------------------------------
	// activity per input: edge seen within its timeout
	// ----------------------------------------------------------------
	logic [2:0] prev_r;
	logic [2:0] live_r;
	logic [1:0] pol_r;

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) prev_r <= '0;
		else     prev_r <= ch_s;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_act
			localparam int TMO = (gi == CH_V) ? FRAME_TIMEOUT : LINE_TIMEOUT;
			logic [CNT_W-1:0] idle_r;
			always_ff @(posedge CLK_SYS or posedge RST) begin
				if (RST) begin
					// no edge seen yet, so nothing counts as live
					idle_r      <= CNT_W'(TMO);
					live_r[gi]  <= 1'b0;
				end else begin
					if (ch_s[gi] != prev_r[gi])
						idle_r <= '0;
					else if (idle_r != CNT_W'(TMO))
						idle_r <= idle_r + 1'b1;
					live_r[gi] <= (idle_r != CNT_W'(TMO));
				end
			end
		end
		// polarity: the shorter phase of the period is the pulse
		for (gi = 0; gi < 2; gi++) begin : g_pol
			logic [CNT_W-1:0] hi_r;
			logic [CNT_W-1:0] lo_r;
			// line polarity is voted, so broad pulses cannot flip it
			logic [2:0]       vote_r;
			always_ff @(posedge CLK_SYS or posedge RST) begin
				if (RST) begin
					hi_r       <= '0;
					lo_r       <= '0;
					vote_r     <= '0;
					pol_r[gi]  <= 1'b0;
				end else if (ch_s[gi] && !prev_r[gi]) begin
					if (hi_r > lo_r && vote_r != 3'h7)
						vote_r <= vote_r + 3'h1;
					else if (hi_r <= lo_r && vote_r != 3'h0)
						vote_r <= vote_r - 3'h1;
					pol_r[gi] <= (gi == CH_H) ? vote_r[2]
						: (hi_r > lo_r); // R07 R08
					hi_r      <= '0;
					lo_r      <= '0;
				end else if (ch_s[gi]) begin
					if (~&hi_r) hi_r <= hi_r + 1'b1;
				end else begin
					if (~&lo_r) lo_r <= lo_r + 1'b1;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// configuration and sync type selection
	// ----------------------------------------------------------------
	logic [7:0] cfg_r;
	logic [7:0] hstart_r;
	logic [7:0] hactive_r;
	logic [7:0] vblank_r;
	logic [7:0] mask_r;
	logic [7:0] traits_r;
	scs_sync_t  type_nxt;
	logic       composite;

	always_comb begin
		if (cfg_r[CFG_SEL+:2] != 2'b00)
			type_nxt = scs_sync_t'(cfg_r[CFG_SEL+:2]);
		else if (live_r[CH_H] && live_r[CH_V])
			type_nxt = SYNC_HV;
		else if (live_r[CH_H])
			type_nxt = SYNC_CS_LINE;
		else if (live_r[CH_G])
			type_nxt = SYNC_CS_GREEN;
		else
			type_nxt = SYNC_NONE; // R06
	end
	assign composite = (type_nxt == SYNC_CS_LINE)
		|| (type_nxt == SYNC_CS_GREEN);

	// ----------------------------------------------------------------
	// line pulse, broad-pulse frame detect, counters
	// ----------------------------------------------------------------
	logic             line_act;
	logic             line_prev_r;
	logic             line_fall;
	logic [CNT_W-1:0] pw_r;
	logic             broad_r;
	logic             frame_act;
	logic             frame_prev_r;
	logic             frame_rise;
	logic [PX_W-1:0]  px_r;
	logic [LN_W-1:0]  ln_r;
	logic [LN_W-1:0]  last_ln_r;
	logic             ilace_r;
	logic             field_r;
	logic             cp_frame_r;
	logic             cp_r;
	logic             tri_line_r;
	logic             tri_r;

	assign line_act  = (type_nxt == SYNC_CS_GREEN) ? ch_s[CH_G]
		: (ch_s[CH_H] ^ pol_r[CH_H]);
	assign line_fall = line_prev_r && !line_act;
	assign frame_act = composite ? broad_r : (ch_s[CH_V] ^ pol_r[CH_V]);
	assign frame_rise = frame_act && !frame_prev_r;

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			line_prev_r  <= 1'b0;
			frame_prev_r <= 1'b0;
			pw_r         <= '0;
			broad_r      <= 1'b0;
		end else begin
			line_prev_r  <= line_act;
			frame_prev_r <= frame_act;
			if (!line_act)
				pw_r <= '0;
			else if (~&pw_r)
				pw_r <= pw_r + 1'b1;
			// broad pulses open the span, the first normal pulse ends it
			if (line_act && pw_r == CNT_W'(WIDE_PULSE_CYC))
				broad_r <= 1'b1; // R02
			else if (line_fall && pw_r < CNT_W'(WIDE_PULSE_CYC))
				broad_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			px_r      <= '0;
			ln_r      <= '0;
			last_ln_r <= '0;
			ilace_r   <= 1'b0;
			field_r   <= 1'b0;
		end else begin
			if (line_act)
				px_r <= '0;
			else if (~&px_r)
				px_r <= px_r + 1'b1;
			if (frame_rise) begin
				ln_r      <= '0;
				last_ln_r <= ln_r;
				// fields whose line counts differ in parity mean interlace
				ilace_r   <= composite && (ln_r[0] != last_ln_r[0]); // R10
				field_r   <= composite && (ln_r[0] != last_ln_r[0])
					&& !field_r; // R05
			end else if (line_fall && ~&ln_r) begin
				ln_r <= ln_r + 1'b1;
			end
			if (!composite) begin
				ilace_r <= 1'b0;
				field_r <= 1'b0;
			end
		end
	end

	// copy protection: narrow pseudo-sync pulses, judged per frame
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cp_frame_r <= 1'b0;
			cp_r       <= 1'b0;
			tri_line_r <= 1'b0;
			tri_r      <= 1'b0;
		end else begin
			if (frame_rise) begin
				cp_r       <= cp_frame_r; // R11
				cp_frame_r <= 1'b0;
			end else if (line_fall && pw_r < CNT_W'(CP_PULSE_CYC)) begin
				cp_frame_r <= 1'b1;
			end
			if (type_nxt != SYNC_CS_GREEN) begin
				tri_line_r <= 1'b0;
				tri_r      <= 1'b0;
			end else if (line_fall) begin
				tri_r      <= tri_line_r || tri_s; // R09
				tri_line_r <= 1'b0;
			end else if (tri_s) begin
				tri_line_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin outputs
	// ----------------------------------------------------------------
	logic [PX_W-1:0] hs_px;
	logic [PX_W-1:0] he_px;

	assign hs_px = {2'b00, hstart_r, 2'b00};
	assign he_px = hs_px + {2'b00, hactive_r, 2'b00};

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RAW_LINE_SYNC_OUT  <= 1'b0;
			RAW_FRAME_SYNC_OUT <= 1'b0;
			VIDEO_VALID_OUT    <= 1'b0;
			FIELD_OUT          <= 1'b0;
		end else begin
			RAW_LINE_SYNC_OUT  <= (type_nxt == SYNC_CS_GREEN)
				? ch_s[CH_G] : ch_s[CH_H]; // R01
			RAW_FRAME_SYNC_OUT <= composite ? broad_r : ch_s[CH_V]; // R02
			VIDEO_VALID_OUT    <= !line_act && !frame_act
				&& ln_r >= {3'b000, vblank_r}
				&& px_r >= hs_px && px_r < he_px; // R04
			FIELD_OUT          <= field_r ^ cfg_r[CFG_FINV]; // R05
		end
	end

	// ----------------------------------------------------------------
	// traits, interrupts, register port
	// ----------------------------------------------------------------
	logic [7:0] traits_nxt;
	logic [7:0] stat_r;
	logic [1:0] evt;
	logic [7:0] stat_nxt;
	logic [7:0] mask_nxt;

	// a mask write acts on the pin in the same cycle as on the register
	assign mask_nxt = (WR && ADDR == ADDR_IRQ_MASK) ? WDATA : mask_r;
	assign traits_nxt = {lock_s, cp_r, ilace_r, tri_r, pol_r[CH_V],
		pol_r[CH_H], type_nxt}; // R12
	assign evt = {PHASE_ADJUST_DONE_EVENT,
		traits_nxt[3:0] != traits_r[3:0]}; // R03
	// set wins over the clear-on-read
	assign stat_nxt = ((RD && ADDR == ADDR_IRQ_STAT) ? 8'h00 : stat_r)
		| {6'h00, evt};

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			traits_r <= '0;
			stat_r   <= '0;
			INT_OUT  <= 1'b0;
			INT_OE_N <= 1'b1;
		end else begin
			traits_r <= traits_nxt; // R13
			stat_r   <= stat_nxt;
			INT_OUT  <= 1'b0;
			INT_OE_N <= ~|(stat_nxt & mask_nxt); // R03
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cfg_r     <= CFG_RST;
			hstart_r  <= HSTART_RST;
			hactive_r <= HACTIVE_RST;
			vblank_r  <= VBLANK_RST;
			mask_r    <= MASK_RST;
		end else if (WR) begin
			case (ADDR)
				ADDR_CFG:      cfg_r     <= WDATA;
				ADDR_HSTART:   hstart_r  <= WDATA;
				ADDR_HACTIVE:  hactive_r <= WDATA;
				ADDR_VBLANK:   vblank_r  <= WDATA;
				ADDR_IRQ_MASK: mask_r    <= WDATA;
				default:       ;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RDATA <= '0;
		end else if (RD) begin
			case (ADDR)
				ADDR_TRAITS:   RDATA <= traits_r;
				ADDR_CFG:      RDATA <= cfg_r;
				ADDR_HSTART:   RDATA <= hstart_r;
				ADDR_HACTIVE:  RDATA <= hactive_r;
				ADDR_VBLANK:   RDATA <= vblank_r;
				ADDR_IRQ_STAT: RDATA <= stat_r;
				ADDR_IRQ_MASK: RDATA <= mask_r;
				default:       RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	green_src_a: assert property ( // R01
		type_nxt == SYNC_CS_GREEN |=> RAW_LINE_SYNC_OUT == $past(ch_s[CH_G]))
		else $error("line sync out does not follow green sync");
	frame_src_a: assert property ( // R02
		type_nxt == SYNC_HV |=> RAW_FRAME_SYNC_OUT == $past(ch_s[CH_V]))
		else $error("frame sync out does not follow vsync");
	irq_pin_a: assert property ( // R03
		(|(stat_r & mask_r)) == !INT_OE_N)
		else $error("interrupt pin disagrees with masked status");
	valid_blank_a: assert property ( // R04
		line_act || frame_act |=> !VIDEO_VALID_OUT)
		else $error("video valid during blanking");
	field_prog_a: assert property ( // R05
		!field_r |=> FIELD_OUT == $past(cfg_r[CFG_FINV]))
		else $error("field output wrong polarity");
	type_force_a: assert property ( // R06
		cfg_r[CFG_SEL+:2] != 2'b00
		|=> traits_r[1:0] == $past(cfg_r[CFG_SEL+:2]))
		else $error("forced sync type not reported");
	tri_green_a: assert property ( // R09
		traits_r[1:0] != 2'b11 |=> !traits_r[TR_TRI])
		else $error("tri-level flag outside green sync");
	ilace_comp_a: assert property ( // R10
		traits_r[1:0] == 2'b01 |=> !traits_r[TR_ILACE])
		else $error("interlace flag on separate sync");
	lock_bit_a: assert property ( // R12
		traits_r[TR_LOCK] == $past(lock_s))
		else $error("lock bit stale");
	ro_read_a: assert property ( // R13
		RD && ADDR == ADDR_TRAITS |=> RDATA == $past(traits_r))
		else $error("traits read returns wrong value");
endmodule : scs_top
`default_nettype wire

// [inc/scs_pkg.sv]
`default_nettype none
package scs_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_NS           = 8;
	// a line input counts as live if edges come faster than 1 kHz
	localparam int LINE_TIMEOUT_NS  = 1_000_000;
	// a frame input counts as live if edges come faster than 20 Hz
	localparam int FRAME_TIMEOUT_NS = 50_000_000;
	localparam int LINE_TIMEOUT_CYC  = LINE_TIMEOUT_NS / CLK_NS;
	localparam int FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_NS / CLK_NS;
	// a line pulse wider than this is a broad (vertical) pulse
	localparam int WIDE_PULSE_NS    = 8000;
	localparam int WIDE_PULSE_CYC   = (WIDE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	// a line pulse narrower than this is a pseudo-sync (copy protection)
	localparam int CP_PULSE_NS      = 1000;
	localparam int CP_PULSE_CYC     = CP_PULSE_NS / CLK_NS;

	localparam int CNT_W = 24;
	localparam int PX_W  = 12;
	localparam int LN_W  = 11;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_TRAITS   = 8'h01;
	localparam logic [7:0] ADDR_CFG      = 8'h10;
	localparam logic [7:0] ADDR_HSTART   = 8'h11;
	localparam logic [7:0] ADDR_HACTIVE  = 8'h12;
	localparam logic [7:0] ADDR_VBLANK   = 8'h13;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h15;

	localparam int TR_HPOL   = 2;
	localparam int TR_VPOL   = 3;
	localparam int TR_TRI    = 4;
	localparam int TR_ILACE  = 5;
	localparam int TR_CP     = 6;
	localparam int TR_LOCK   = 7;
	localparam int CFG_FINV  = 0;
	localparam int CFG_SEL   = 1;
	localparam int IRQ_MODE  = 0;
	localparam int IRQ_CMD   = 1;

	localparam logic [7:0] CFG_RST     = 8'h00;
	localparam logic [7:0] HSTART_RST  = 8'h20;
	localparam logic [7:0] HACTIVE_RST = 8'hc8;
	localparam logic [7:0] VBLANK_RST  = 8'h14;
	localparam logic [7:0] MASK_RST    = 8'h00;

	localparam int CH_H = 0;
	localparam int CH_V = 1;
	localparam int CH_G = 2;

	typedef enum logic [1:0] {
		SYNC_NONE, SYNC_HV, SYNC_CS_LINE, SYNC_CS_GREEN
	} scs_sync_t;
endpackage : scs_pkg
`default_nettype wire

// [rtl/scs_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : scs_sync2
`default_nettype wire

// [tb/scs_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_src_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pol_h,
	input  wire logic pol_v,
	input  wire logic cs,
	input  wire logic cp,
	input  wire logic il,
	output var  logic h,
	output var  logic v
);
	// ----------------------------------------------------------------
	// line and frame timing
	// ----------------------------------------------------------------
	logic [10:0] pos_r;
	logic [3:0]  line_r;
	logic        fld_r;
	logic [10:0] len;
	logic [10:0] wid;
	logic [3:0]  nl;
	logic        brd;

	// three broad lines open a composite frame
	assign brd = cs && (line_r < 4'h3);
	assign len = brd ? 11'h4b0 : 11'h12c;
	// one short pseudo pulse on line 5
	assign wid = brd ? 11'h44c
		: (cp && line_r == 4'h5) ? 11'h032 : 11'h082;
	// odd field one line longer, so line counts differ in parity
	assign nl = (il && fld_r) ? 4'hb : 4'ha;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos_r  <= '0;
			line_r <= '0;
			fld_r  <= 1'b0;
		end else if (pos_r == len - 11'h001) begin
			pos_r <= '0;
			if (line_r == nl - 4'h1) begin
				line_r <= '0;
				fld_r  <= ~fld_r;
			end else begin
				line_r <= line_r + 4'h1;
			end
		end else begin
			pos_r <= pos_r + 11'h001;
		end
	end

	// polarity applied at the pin; held still while in reset
	assign h = rst ? 1'b0 : ((pos_r < wid) ^ pol_h);
	assign v = rst ? 1'b0 : ((!cs && line_r < 4'h2) ^ pol_v);
endmodule : scs_src_model
`default_nettype wire

// [tb/tb_sync_characterization_status.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sync_characterization_status;
	import scs_pkg::*;
	// shortened live timeouts keep the run short
	localparam int LT = 1500;
	localparam int FT = 4000;
	logic       clk, rst, idle, lock, cmd, wr, rd, chk, f1;
	logic       pol_h, pol_v, cs, cp, il, grn, tri_en, h, v;
	logic       lso, fso, vvo, fo, io, ioe;
	logic [7:0] addr, wdata, rdata, d;
	logic [2:0] sh_h, sh_v;
	logic [7:0] ra [6];
	logic [7:0] re [6];
	int         failures, n_checks, cyc;

	scs_src_model src (.clk(clk), .rst(rst | idle), .pol_h(pol_h),
		.pol_v(pol_v), .cs(cs), .cp(cp), .il(il), .h(h), .v(v));

	scs_top #(.LINE_TIMEOUT(LT), .FRAME_TIMEOUT(FT)) uut (
		.CLK_SYS(clk), .RST(rst), .HSYNC_IN(grn ? 1'b0 : h),
		.VSYNC_IN(v), .GREEN_SYNC_IN(grn ? h : 1'b0),
		.GREEN_TRI_IN(tri_en & h), .PLL_LOCK_IN(lock),
		.PHASE_ADJUST_DONE_EVENT(cmd), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .RAW_LINE_SYNC_OUT(lso),
		.RAW_FRAME_SYNC_OUT(fso), .VIDEO_VALID_OUT(vvo),
		.FIELD_OUT(fo), .INT_OUT(io), .INT_OE_N(ioe));

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp

	task automatic wreg(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		addr  <= a;
		wdata <= x;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	// read data are looked at only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg

	task automatic at(input int l, input int p);
		do begin
			@(posedge clk);
			#1;
		end while (!(src.line_r == l && src.pos_r == p));
	endtask : at

	task automatic frames(input int n);
		repeat (n) at(0, 0);
	endtask : frames

	task automatic pulse;
		@(posedge clk);
		cmd <= 1'b1;
		@(posedge clk);
		cmd <= 1'b0;
		@(posedge clk);
		#1;
	endtask : pulse

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// pins reach the outputs three edges later
	always @(posedge clk) begin
		sh_h <= {sh_h[1:0], h};
		sh_v <= {sh_v[1:0], v};
		cyc  <= cyc + 1;
		if (cyc == 99000) begin
			failures++;
			end_sim();
		end
	end

	always @(negedge clk) begin
		if (chk) begin
			cmp({7'h00, lso}, {7'h00, sh_h[2]});
			if (!cs)
				cmp({7'h00, fso}, {7'h00, sh_v[2]});
		end
	end

	initial begin
		{rst, idle} = 2'b11;
		{lock, cmd, wr, rd, chk, pol_h, pol_v} = '0;
		{cs, cp, il, grn, tri_en, f1} = '0;
		{addr, wdata, d} = '0;
		{sh_h, sh_v} = '0;
		{failures, n_checks, cyc} = '0;
		ra = '{ADDR_TRAITS, ADDR_CFG, ADDR_HSTART, ADDR_HACTIVE,
			ADDR_IRQ_MASK, 8'h7f};
		re = '{8'h00, CFG_RST, HSTART_RST, HACTIVE_RST, MASK_RST, 8'h00};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		cmp({7'h00, ioe}, 8'h01);
		foreach (ra[i]) begin
			rreg(ra[i]);
			cmp(d, re[i]);
		end
		rreg(ADDR_VBLANK);
		cmp(d, VBLANK_RST);
		wreg(8'h7f, 8'ha5);
		rreg(8'h7f);
		cmp(d, 8'h00);
		wreg(ADDR_HSTART, 8'h02);
		wreg(ADDR_HACTIVE, 8'h20);
		wreg(ADDR_VBLANK, 8'h03);
		wreg(ADDR_IRQ_MASK, 8'h03);
		// separate syncs, active high, loop locked
		lock <= 1'b1;
		idle <= 1'b0;
		chk  <= 1'b1;
		frames(2);
		rreg(ADDR_TRAITS);
		cmp(d, 8'h81);
		wreg(ADDR_TRAITS, 8'hff);
		rreg(ADDR_TRAITS);
		cmp(d, 8'h81);
		at(8, 200);
		cmp({7'h00, vvo}, 8'h01);
		at(8, 50);
		cmp({7'h00, vvo}, 8'h00);
		at(0, 200);
		cmp({7'h00, vvo}, 8'h00);
		rreg(ADDR_IRQ_STAT);
		cmp({7'h00, ioe}, 8'h01);
		// both polarities flip: a mode change
		pol_h <= 1'b1;
		pol_v <= 1'b1;
		lock  <= 1'b0;
		frames(2);
		cmp({6'h00, io, ioe}, 8'h00);
		rreg(ADDR_IRQ_STAT);
		cmp(d & 8'h01, 8'h01);
		rreg(ADDR_IRQ_STAT);
		cmp(d, 8'h00);
		cmp({7'h00, ioe}, 8'h01);
		rreg(ADDR_TRAITS);
		cmp(d, 8'h0d);
		// command done, masked then enabled
		wreg(ADDR_IRQ_MASK, 8'h01);
		pulse();
		cmp({7'h00, ioe}, 8'h01);
		rreg(ADDR_IRQ_STAT);
		cmp(d, 8'h02);
		wreg(ADDR_IRQ_MASK, 8'h02);
		pulse();
		cmp({7'h00, ioe}, 8'h00);
		rreg(ADDR_IRQ_STAT);
		cmp({7'h00, ioe}, 8'h01);
		// composite on the line pin, interlaced, pseudo pulses
		{pol_h, pol_v, lock} <= 3'b001;
		{cs, cp, il} <= 3'b111;
		frames(3);
		at(8, 0);
		rreg(ADDR_TRAITS);
		cmp(d & 8'hf7, 8'he2);
		at(1, 10);
		cmp({7'h00, fso}, 8'h01);
		at(6, 10);
		cmp({7'h00, fso}, 8'h00);
		f1 = fo;
		at(6, 0);
		cmp({7'h00, fo}, {7'h00, ~f1});
		wreg(ADDR_CFG, 8'h01);
		at(6, 0);
		cmp({7'h00, fo}, {7'h00, ~f1});
		// forced composite on green, tri-level, progressive
		chk <= 1'b0;
		wreg(ADDR_CFG, 8'h06);
		{grn, tri_en, il} <= 3'b110;
		frames(3);
		chk <= 1'b1;
		rreg(ADDR_TRAITS);
		cmp(d & 8'h33, 8'h13);
		tri_en <= 1'b0;
		frames(1);
		rreg(ADDR_TRAITS);
		cmp(d & 8'h10, 8'h00);
		end_sim();
	end
endmodule : tb_sync_characterization_status
`default_nettype wire
